// ==== core/bit_call_exec.v ====
// execution core for and-immediate, set-bit, bit-test-skip and call instructions
// How it works
// RULE1: and_immediate_to_accumulator ands the accumulator with an 8-bit immediate, stores it back, and updates only Z.
// RULE2: set_register_bit forces one bit of the addressed register to one, keeps the rest, and changes no flag.
// RULE3: bit-test instructions carry a six-bit register address 0..63 and a three-bit bit index 0..7.
// RULE4: test_bit_skip_if_clear discards the fetched next instruction and runs a no-op when the bit is zero.
// RULE5: test_bit_skip_if_set discards the fetched next instruction and runs a no-op when the bit is one.
// RULE6: a bit test takes one cycle without a skip, two with a skip, and changes no flag.
// RULE7: both calls push program_counter plus one onto the return stack before jumping.
// RULE8: a call writes the return address at the stack pointer and then raises the pointer by one.
// RULE9: the direct call loads the immediate into pc bits 7:0 and high-byte buffer bits 1:0 into 9:8.
// RULE10: indirect_subroutine_call loads table_high_pointer bits 1:0 into pc 9:8 and the accumulator into 7:0.
// RULE11: a pc_high_byte_buffer register supplies the upper pc bits for direct calls.
// RULE12: calls take two cycles and change no flag; and-immediate and set-bit take one cycle.
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "bit_call_map.vh"

module bit_call_exec (
    input  wire                 clk_sys,
    input  wire                 sys_rst,
    input  wire [`INSN_W-1:0]   insn_word,
    output wire [`PC_W-1:0]     fetch_addr,
    output wire                 insn_taken,
    output wire                 exec_nop,
    output wire [`SP_W-1:0]     stack_ptr,
    output wire [`PC_W-1:0]     stack_top,
    input  wire [7:0]           reg_addr,
    input  wire [7:0]           reg_wdata,
    input  wire                 reg_wr,
    input  wire                 reg_rd,
    output reg  [7:0]           reg_rdata
);
    // ------------------------------------------------------------
    // local state
    // ------------------------------------------------------------
    localparam ST_EXEC = 1'b0;
    localparam ST_FLUSH = 1'b1;

    reg [7:0]        acc_q;
    reg [7:0]        acc_d;
    reg              zero_q;
    reg              zero_d;
    reg [`PC_W-1:0]  pc_q;
    reg [`PC_W-1:0]  pc_d;
    reg [1:0]        hbuf_q;
    reg [1:0]        table_high_pointer_q;
    reg              state_q;
    reg              state_d;
    reg [7:0]        rf_q [0:`RF_DEPTH-1];
    reg              rf_we;
    reg [5:0]        rf_wa;
    reg [7:0]        rf_wd;
    reg              push;
    reg [7:0]        rdata_d;
    wire [4:0]       opc;
    wire [7:0]       imm;
    wire [5:0]       raddr;
    wire [2:0]       bsel;
    wire [7:0]       rval;
    wire             tbit;
    wire [`PC_W-1:0] pc_next;

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    // six-bit register field, three-bit bit field
    assign opc   = insn_word[`OPC_HI:`OPC_LO];
    assign imm   = insn_word[`IMM_HI:`IMM_LO];
    assign raddr = insn_word[`REG_HI:`REG_LO]; // RULE3
    assign bsel  = insn_word[`BIT_HI:`BIT_LO]; // RULE3
    assign rval  = rf_q[raddr];
    assign tbit  = rval[bsel];
    assign pc_next = pc_q + 10'h001;

    // mask with a single one at the selected bit
    function [7:0] bit_mask;
        input [2:0] idx;
        begin
            bit_mask = 8'h01 << idx;
        end
    endfunction

    // ------------------------------------------------------------
    // execute
    // ------------------------------------------------------------
    // ST_FLUSH spends one cycle on a no-op while the new word is fetched
    always @* begin
        acc_d   = acc_q;
        zero_d  = zero_q;
        pc_d    = pc_next;
        state_d = ST_EXEC;
        rf_we   = 1'b0;
        rf_wa   = raddr;
        rf_wd   = rval;
        push    = 1'b0;
        if (state_q == ST_FLUSH) begin
            pc_d = pc_q; // second cycle of skip or call, nothing executes
        end else begin
            case (opc)
                `OPC_AND_IMM: begin
                    acc_d  = acc_q & imm; // RULE1
                    zero_d = ((acc_q & imm) == 8'h00); // RULE1
                end
                `OPC_SET_BIT: begin
                    rf_we = 1'b1;
                    rf_wd = rval | bit_mask(bsel); // RULE2
                end
                `OPC_SKIP_CLR: begin
                    if (!tbit) begin
                        pc_d    = pc_q + 10'h002; // RULE4
                        state_d = ST_FLUSH; // RULE6
                    end
                end
                `OPC_SKIP_SET: begin
                    if (tbit) begin
                        pc_d    = pc_q + 10'h002; // RULE5
                        state_d = ST_FLUSH; // RULE6
                    end
                end
                `OPC_CALL_DIR: begin
                    push    = 1'b1; // RULE7
                    pc_d    = {hbuf_q, imm}; // RULE9
                    state_d = ST_FLUSH; // RULE12
                end
                `OPC_CALL_IND: begin
                    push    = 1'b1; // RULE7
                    pc_d    = {table_high_pointer_q, acc_q}; // RULE10
                    state_d = ST_FLUSH; // RULE12
                end
                default: begin
                    pc_d = pc_next;
                end
            endcase
        end
    end

    // core registers; bus writes only land when no instruction touches them
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            acc_q   <= `ACC_RST;
            zero_q  <= `Z_RST;
            pc_q    <= `PC_RST;
            hbuf_q  <= `HBUF_RST;
            table_high_pointer_q  <= `TABLE_HIGH_POINTER_RST;
            state_q <= ST_EXEC;
        end else begin
            acc_q   <= acc_d;
            zero_q  <= zero_d;
            pc_q    <= pc_d;
            state_q <= state_d;
            // a flushed and-immediate word does not execute, so it must not block the bus
            if (reg_wr && reg_addr == `ADR_ACC
                && !(state_q == ST_EXEC && opc == `OPC_AND_IMM)) begin
                acc_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == `ADR_HBUF) begin
                hbuf_q <= reg_wdata[1:0]; // RULE11
            end
            if (reg_wr && reg_addr == `ADR_TABLE_HIGH_POINTER) begin
                table_high_pointer_q <= reg_wdata[1:0];
            end
        end
    end

    // register file; the instruction port wins over the bus
    always @(posedge clk_sys) begin
        if (rf_we) begin
            rf_q[rf_wa] <= rf_wd;
        end else if (reg_wr && reg_addr[7:6] == 2'b01) begin
            rf_q[reg_addr[5:0]] <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // return stack
    // ------------------------------------------------------------
    return_stack u_stack (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .push      (push),
        .push_addr (pc_next),
        .sp        (stack_ptr),
        .top_addr  (stack_top)
    );

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    // unmapped offsets read as zero
    always @* begin
        case (reg_addr)
            `ADR_ACC:    rdata_d = acc_q;
            `ADR_STATUS: rdata_d = {7'h00, zero_q};
            `ADR_PC_LO:  rdata_d = pc_q[7:0];
            `ADR_PC_HI:  rdata_d = {6'h00, pc_q[9:8]};
            `ADR_HBUF:   rdata_d = {6'h00, hbuf_q};
            `ADR_TABLE_HIGH_POINTER:   rdata_d = {6'h00, table_high_pointer_q};
            `ADR_SP:     rdata_d = {5'h00, stack_ptr};
            default: begin
                if (reg_addr[7:6] == 2'b01) begin
                    rdata_d = rf_q[reg_addr[5:0]];
                end else begin
                    rdata_d = 8'h00;
                end
            end
        endcase
    end

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= `RDATA_RST;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    assign fetch_addr = pc_q;
    assign insn_taken = (state_q == ST_EXEC);
    assign exec_nop   = (state_q == ST_FLUSH);
endmodule

`default_nettype wire

// ==== core/bit_call_map.vh ====
// constants for the bit-logic and call execution core
`ifndef BIT_CALL_MAP_VH
`define BIT_CALL_MAP_VH

// ------------------------------------------------------------
// instruction word layout (14-bit word)
// ------------------------------------------------------------
`define INSN_W          14
`define OPC_HI          13
`define OPC_LO          9
`define IMM_HI          7
`define IMM_LO          0
`define REG_HI          5
`define REG_LO          0
`define BIT_HI          8
`define BIT_LO          6

// ------------------------------------------------------------
// opcodes held in bits 13:9
// ------------------------------------------------------------
`define OPC_NOP         5'h00
`define OPC_AND_IMM     5'h01
`define OPC_SET_BIT     5'h02
`define OPC_SKIP_CLR    5'h03
`define OPC_SKIP_SET    5'h04
`define OPC_CALL_DIR    5'h05
`define OPC_CALL_IND    5'h06

// ------------------------------------------------------------
// sizes and reset values
// ------------------------------------------------------------
`define PC_W            10
`define STACK_DEPTH     8
`define SP_W            3
`define RF_DEPTH        64
`define ACC_RST         8'h00
`define PC_RST          10'h000
`define SP_RST          3'h0
`define HBUF_RST        2'h0
`define TABLE_HIGH_POINTER_RST        2'h0
`define Z_RST           1'b0
`define RDATA_RST       8'h00

// ------------------------------------------------------------
// register bus offsets for locally held state
// ------------------------------------------------------------
`define ADR_ACC         8'h00
`define ADR_STATUS      8'h01
`define ADR_PC_LO       8'h02
`define ADR_PC_HI       8'h03
`define ADR_HBUF        8'h04
`define ADR_TABLE_HIGH_POINTER        8'h05
`define ADR_SP          8'h06
`define ADR_RF_BASE     8'h40
`define ST_Z_BIT        0

`endif

// ==== core/return_stack.v ====
// hardware return stack for subroutine calls
`timescale 1ns/1ns
`default_nettype none
`include "bit_call_map.vh"

module return_stack (
    input  wire                 clk_sys,
    input  wire                 sys_rst,
    input  wire                 push,
    input  wire [`PC_W-1:0]     push_addr,
    output wire [`SP_W-1:0]     sp,
    output wire [`PC_W-1:0]     top_addr
);
    reg [`PC_W-1:0] entry_q [0:`STACK_DEPTH-1];
    reg [`SP_W-1:0] sp_q;
    reg [`SP_W-1:0] sp_d;

    // ------------------------------------------------------------
    // pointer update
    // ------------------------------------------------------------
    // next pointer: one past the entry just written
    always @* begin
        sp_d = sp_q;
        if (push) begin
            sp_d = sp_q + 3'h1; // RULE8
        end
    end

    // pointer wraps silently; depth overflow is the program's problem
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sp_q <= `SP_RST;
        end else begin
            sp_q <= sp_d;
        end
    end

    // entries carry no reset, they are only read after a push
    always @(posedge clk_sys) begin
        if (push) begin
            entry_q[sp_q] <= push_addr; // RULE8
        end
    end

    assign sp       = sp_q;
    assign top_addr = entry_q[sp_q - 3'h1];
endmodule

`default_nettype wire

// ==== bench/prog_memory.sv ====
// program memory model feeding instruction words to the core
`timescale 1ns/1ns
`default_nettype none
`include "bit_call_map.vh"
module prog_memory (
    input wire logic [`PC_W-1:0]   fetch_addr,
    input wire logic               clk_sys,
    input wire logic               load_en,
    input wire logic [`PC_W-1:0]   load_addr,
    input wire logic [`INSN_W-1:0] load_word,
    output logic [`INSN_W-1:0]     insn_word
);
    logic [`INSN_W-1:0] mem [0:1023];
    // unloaded words read as no-op
    initial begin
        for (int i = 0; i < 1024; i++) mem[i] = 14'h0000;
    end
    // bench loads the program while the core sits in reset
    always @(posedge clk_sys) begin
        if (load_en) mem[load_addr] <= load_word;
    end
    // same-cycle read, as the core expects
    assign insn_word = mem[fetch_addr];
endmodule
`default_nettype wire

// ==== bench/bit_call_monitor.sv ====
// checker for the bit-logic and call execution core
`timescale 1ns/1ns
`default_nettype none
`include "bit_call_map.vh"
module bit_call_monitor (
    input wire logic               clk_sys,
    input wire logic               sys_rst,
    input wire logic [`INSN_W-1:0] insn_word,
    input wire logic [`PC_W-1:0]   fetch_addr,
    input wire logic               insn_taken,
    input wire logic               exec_nop,
    input wire logic [`SP_W-1:0]   stack_ptr,
    input wire logic [`PC_W-1:0]   stack_top
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // opcode only counts when the word really executes
    wire logic [4:0] op;
    wire logic [7:0] imm;
    assign op = insn_taken ? insn_word[`OPC_HI:`OPC_LO] : 5'h1F;
    assign imm = insn_word[`IMM_HI:`IMM_LO];
    wire logic call = (op == `OPC_CALL_DIR) || (op == `OPC_CALL_IND);
    wire logic test = (op == `OPC_SKIP_CLR) || (op == `OPC_SKIP_SET);
    property p_pair; exec_nop |-> $past(call || test); endproperty
    a_pair: assert property (p_pair) else $error("nop flag mismatch");
    property p_once; exec_nop |=> !exec_nop; endproperty
    a_once: assert property (p_once) else $error("nop too long");
    property p_hold; exec_nop |=> fetch_addr == $past(fetch_addr); endproperty
    a_hold: assert property (p_hold) else $error("pc moved in nop");
    property p_one; (op == `OPC_AND_IMM || op == `OPC_SET_BIT)
        |=> !exec_nop && fetch_addr == $past(fetch_addr) + 10'h001; endproperty
    a_one: assert property (p_one) else $error("single cycle broken");
    property p_test; test |=> (exec_nop && fetch_addr == $past(fetch_addr) + 10'h002)
        || (!exec_nop && fetch_addr == $past(fetch_addr) + 10'h001); endproperty
    a_test: assert property (p_test) else $error("bit test timing");
    property p_push; call |=> exec_nop && stack_top == $past(fetch_addr) + 10'h001;
    endproperty
    a_push: assert property (p_push) else $error("bad return address");
    property p_sp; call |=> stack_ptr == $past(stack_ptr) + 3'h1; endproperty
    a_sp: assert property (p_sp) else $error("stack pointer");
    property p_dir; op == `OPC_CALL_DIR |=> fetch_addr[7:0] == $past(imm); endproperty
    a_dir: assert property (p_dir) else $error("direct target");
    c_skip: cover property (test ##1 exec_nop);
    c_dir: cover property (op == `OPC_CALL_DIR);
    c_ind: cover property (op == `OPC_CALL_IND);
endmodule
bind bit_call_exec bit_call_monitor mon_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .insn_word(insn_word), .fetch_addr(fetch_addr), .insn_taken(insn_taken),
    .exec_nop(exec_nop), .stack_ptr(stack_ptr), .stack_top(stack_top));
`default_nettype wire

// ==== bench/test_mcu_bit_logic_call_execute.sv ====
// self-checking bench for the bit-logic and call execution core
`timescale 1ns/1ns
`default_nettype none
`include "bit_call_map.vh"
module test_mcu_bit_logic_call_execute;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  ra = 8'h00;
    logic [7:0]  rw = 8'h00;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic        ld = 1'b0;
    logic [9:0]  la = 10'h000;
    logic [13:0] lw = 14'h0000;
    wire [13:0]  iw;
    wire [9:0]   pc;
    wire [9:0]   top;
    wire [2:0]   sp;
    wire         nop;
    wire [7:0]   rdat;
    logic [7:0]  q[$];
    logic        rd_p = 1'b0;
    int          num_errors = 0;
    int          n_tests = 0;
    logic [7:0]  acc, imm, v, tg;
    logic [5:0]  r;
    logic [2:0]  b;
    logic [1:0]  h, t;
    bit_call_exec dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .insn_word(iw),
        .fetch_addr(pc), .insn_taken(), .exec_nop(nop), .stack_ptr(sp),
        .stack_top(top), .reg_addr(ra), .reg_wdata(rw), .reg_wr(wr_s),
        .reg_rd(rd_s), .reg_rdata(rdat));
    prog_memory mem_u (.clk_sys(clk_sys), .load_en(ld), .load_addr(la),
        .load_word(lw), .fetch_addr(pc), .insn_word(iw));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic load(input logic [9:0] a, input logic [13:0] w);
        @(posedge clk_sys);
        ld <= 1'b1;
        la <= a;
        lw <= w;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        wr_s <= 1'b1;
        ra <= a;
        rw <= d;
        @(posedge clk_sys);
        wr_s <= 1'b0;
    endtask
    // expected read data queued here, compared by the watcher below
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        rd_s <= 1'b1;
        ra <= a;
        q.push_back(e);
        @(posedge clk_sys);
        rd_s <= 1'b0;
    endtask
    task automatic step(input logic [9:0] p, input logic n, input logic [2:0] s);
        @(posedge clk_sys);
        #1;
        chk("fetch_addr", p, pc);
        chk("exec_nop", n, nop);
        chk("stack_ptr", s, sp);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge clk_sys) rd_p <= rd_s;
    always @(negedge clk_sys) begin
        if (rd_p) chk("reg_rdata", q.pop_front(), rdat);
        else chk("reg_rdata_idle", 16'h0000, rdat);
    end
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    // whole run is under a hundred cycles
    initial begin
        repeat (3000) @(posedge clk_sys);
        num_errors++;
        end_sim();
    end
    initial begin
        void'($urandom(78945));
        {acc, imm, v, tg, b} = {$urandom, $urandom};
        r = 6'($urandom % 63);
        h = 2'($urandom % 3 + 1);
        t = (h == 2'h3) ? 2'h1 : h + 2'h1;
        // skipped words would clear the accumulator if executed
        load(10'h010, {`OPC_AND_IMM, 1'b0, imm});
        load(10'h011, {`OPC_SET_BIT, b, r});
        load(10'h012, {`OPC_SKIP_CLR, b, r});
        load(10'h013, {`OPC_SKIP_SET, b, r});
        load(10'h014, 14'h0200);
        load(10'h015, {`OPC_SKIP_CLR, b, r + 6'h01});
        load(10'h016, 14'h0200);
        load(10'h017, {`OPC_SKIP_SET, b, r + 6'h01});
        load(10'h018, {`OPC_CALL_DIR, 1'b0, tg});
        load({h, tg}, {`OPC_CALL_IND, 9'h000});
        load({t, acc & imm}, {`OPC_CALL_IND, 9'h000});
        @(posedge clk_sys);
        ld <= 1'b0;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        wr(`ADR_ACC, acc);
        wr(`ADR_RF_BASE + r, v);
        wr(`ADR_RF_BASE + r + 8'h01, 8'h00);
        wr(`ADR_HBUF, {6'h00, h});
        wr(`ADR_TABLE_HIGH_POINTER, {6'h00, t});
        #1;
        for (int k = 0; k < 40 && pc !== 10'h010; k++) @(posedge clk_sys) #1;
        step(10'h011, 1'b0, 3'h0);
        step(10'h012, 1'b0, 3'h0);
        step(10'h013, 1'b0, 3'h0);
        step(10'h015, 1'b1, 3'h0);
        step(10'h015, 1'b0, 3'h0);
        step(10'h017, 1'b1, 3'h0);
        step(10'h017, 1'b0, 3'h0);
        step(10'h018, 1'b0, 3'h0);
        step({h, tg}, 1'b1, 3'h1);
        chk("stack_top", 10'h019, top);
        step({h, tg}, 1'b0, 3'h1);
        step({t, acc & imm}, 1'b1, 3'h2);
        chk("stack_top", 10'({h, tg} + 10'h001), top);
        $display("test trace done");
        rd(`ADR_ACC, acc & imm);
        wr(`ADR_STATUS, 8'hFF);
        rd(`ADR_STATUS, {7'h00, (acc & imm) == 8'h00});
        rd(`ADR_RF_BASE + r, v | (8'h01 << b));
        rd(`ADR_RF_BASE + r + 8'h01, 8'h00);
        rd(`ADR_HBUF, {6'h00, h});
        rd(`ADR_TABLE_HIGH_POINTER, {6'h00, t});
        rd(8'h80, 8'h00);
        repeat (2) @(posedge clk_sys);
        $display("test registers done");
        end_sim();
    end
endmodule
`default_nettype wire
